// ---- src/pior_pkg.sv ----
// Constants and encodings for the sixteen-channel programmable I/O register
package pior_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int CHANNELS  = 16;
  localparam int CFG_W     = 4;
  localparam int FUNC_W    = 5;
  localparam int ADDR_W    = 4;
  localparam int DATA_W    = 16;
  localparam int STB_CFG_W = 3;

  // ---------------------------------------------------------------
  // Dataway function codes
  // ---------------------------------------------------------------
  localparam logic [FUNC_W-1:0] F_READ      = 5'h00;
  localparam logic [FUNC_W-1:0] F_READ_CFG  = 5'h01;
  localparam logic [FUNC_W-1:0] F_READ_CLR  = 5'h02;
  localparam logic [FUNC_W-1:0] F_TEST_LAM  = 5'h08;
  localparam logic [FUNC_W-1:0] F_INIT      = 5'h09;
  localparam logic [FUNC_W-1:0] F_WRITE     = 5'h10;
  localparam logic [FUNC_W-1:0] F_WRITE_CFG = 5'h11;
  localparam logic [FUNC_W-1:0] F_LAM_OFF   = 5'h18;
  localparam logic [FUNC_W-1:0] F_LAM_ON    = 5'h1A;
  localparam logic [FUNC_W-1:0] F_TEST_INT  = 5'h1B;

  // ---------------------------------------------------------------
  // Subaddresses
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] A_DATA   = 4'h0;
  localparam logic [ADDR_W-1:0] A_STROBE = 4'h1;
  localparam logic [ADDR_W-1:0] A_MASK   = 4'h2;

  // ---------------------------------------------------------------
  // Channel configuration fields
  // ---------------------------------------------------------------
  localparam int CFG_DIR_BIT  = 0;
  localparam int CFG_POL_BIT  = 1;
  localparam int CFG_MODE_BIT = 2;
  localparam int CFG_XFER_BIT = 3;
  localparam logic [CFG_W-1:0] CFG_RESET = 4'h7;

  // ---------------------------------------------------------------
  // Strobe configuration fields
  // ---------------------------------------------------------------
  localparam int STB_POL_BIT = 0;
  localparam int STB_LAM_BIT = 1;
  localparam int STB_OCC_BIT = 2;
  localparam logic [STB_CFG_W-1:0] STB_CFG_RESET = 3'h0;

  // ---------------------------------------------------------------
  // Other reset and read padding values
  // ---------------------------------------------------------------
  localparam logic [DATA_W-1:0] WORD_ZERO = 16'h0000;
  localparam logic [DATA_W-STB_CFG_W-1:0] STB_PAD = 13'h0000;

endpackage

// ---- src/pior_cfg_bank.sv ----
// Bank of per-channel configuration words
`timescale 1ns/1ps
module pior_cfg_bank (
  // Clock and reset
  input  wire logic                                          clk,
  input  wire logic                                          rst_b,
  // Control
  input  wire logic                                          init,
  input  wire logic                                          wrEn,
  input  wire logic [pior_pkg::ADDR_W-1:0]                   wrAddr,
  input  wire logic [pior_pkg::CFG_W-1:0]                    wrData,
  // Parallel view of all words
  output logic      [pior_pkg::CHANNELS-1:0][pior_pkg::CFG_W-1:0] cfgAll
);
  import pior_pkg::*;

  typedef struct packed {
    logic [CHANNELS-1:0][CFG_W-1:0] word;
  } pior_bank_t;

  pior_bank_t cur;
  pior_bank_t next_cur;

  always_comb begin
    next_cur = cur;
    if (init) begin
      for (int i = 0; i < CHANNELS; i++) begin
        next_cur.word[i] = CFG_RESET;
      end
    end else if (wrEn) begin
      next_cur.word[wrAddr] = wrData;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      for (int i = 0; i < CHANNELS; i++) begin
        cur.word[i] <= CFG_RESET;
      end
    end else begin
      cur <= next_cur;
    end
  end

  assign cfgAll = cur.word;

endmodule

// ---- src/pior_io_register.sv ----
// Sixteen-channel programmable I/O register, dataway slave with LAM
`timescale 1ns/1ps
module pior_io_register (
  // Clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst_b,
  // Dataway command, one cycle per operation
  input  wire logic                          cycleStrobe,
  input  wire logic [pior_pkg::FUNC_W-1:0]   func,
  input  wire logic [pior_pkg::ADDR_W-1:0]   subAddr,
  input  wire logic [pior_pkg::DATA_W-1:0]   writeData,
  input  wire logic                          datawayClear,
  // Dataway answer
  output logic      [pior_pkg::DATA_W-1:0]   readData,
  output logic                               qResp,
  output logic                               respValid,
  output logic                               lamLine,
  // Channel pins
  input  wire logic [pior_pkg::CHANNELS-1:0] chanIn,
  output logic      [pior_pkg::CHANNELS-1:0] chanOut,
  output logic      [pior_pkg::CHANNELS-1:0] chanOe,
  // Strobe input
  input  wire logic                          strobe_input,
  // Front indicators
  output logic      [pior_pkg::CHANNELS-1:0] channel_direction_indicator,
  output logic                               lamIndicator
);
  import pior_pkg::*;

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [DATA_W-1:0]    outLatch;
    logic [DATA_W-1:0]    inLatch;
    logic [DATA_W-1:0]    lamMask;
    logic [STB_CFG_W-1:0] strobeCfg;
    logic                 lamLineEn;
    logic                 strobePrev;
    logic [CHANNELS-1:0]  levelPrev;
    logic [CHANNELS-1:0]  driveVal;
    logic [CHANNELS-1:0]  pinOut;
    logic [CHANNELS-1:0]  dirLed;
    logic [DATA_W-1:0]    readData;
    logic                 qResp;
    logic                 respValid;
    logic                 lamLine;
    logic                 lamLed;
  } pior_state_t;

  pior_state_t cur;
  pior_state_t next_cur;

  logic [CHANNELS-1:0][CFG_W-1:0] cfgAll;
  logic [CHANNELS-1:0]            levelIn;
  logic [CHANNELS-1:0]            cfgIsIn;
  logic [CHANNELS-1:0]            cfgPol;
  logic [CHANNELS-1:0]            cfgNormal;
  logic [CHANNELS-1:0]            cfgStrobed;
  logic                           initReq;
  logic                           cfgWr;

  // ---------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------
  function automatic logic isCmd(input logic                valid,
                                 input logic [FUNC_W-1:0]   f,
                                 input logic [ADDR_W-1:0]   a,
                                 input logic [FUNC_W-1:0]   fWant,
                                 input logic [ADDR_W-1:0]   aWant);
    isCmd = valid && (f == fWant) && (a == aWant);
  endfunction

  assign initReq = datawayClear | isCmd(cycleStrobe, func, subAddr, F_INIT, A_DATA);
  assign cfgWr   = cycleStrobe && (func == F_WRITE_CFG);

  // ---------------------------------------------------------------
  // Channel configuration bank
  // ---------------------------------------------------------------
  pior_cfg_bank u_cfg_bank (
    .clk    (clk),
    .rst_b  (rst_b),
    .init   (initReq),
    .wrEn   (cfgWr),
    .wrAddr (subAddr),
    .wrData (writeData[CFG_W-1:0]),
    .cfgAll (cfgAll)
  );

  // ---------------------------------------------------------------
  // Per-channel field split and polarity
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : gChan
      assign cfgIsIn[g]    = cfgAll[g][CFG_DIR_BIT];
      assign cfgPol[g]     = cfgAll[g][CFG_POL_BIT];
      assign cfgNormal[g]  = cfgAll[g][CFG_MODE_BIT];
      assign cfgStrobed[g] = cfgAll[g][CFG_XFER_BIT];
      assign levelIn[g]    = cfgPol[g] ? chanIn[g] : ~chanIn[g];
    end
  endgenerate

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  logic                strobeActive;
  logic                strobeEvent;
  logic                clrIn;
  logic                clrOcc;
  logic [DATA_W-1:0]   readPattern;
  logic                lamInt;
  logic                lamNext;
  logic                setBit;

  always_comb begin
    next_cur     = cur;
    strobeActive = 1'b0;
    strobeEvent  = 1'b0;
    clrIn        = 1'b0;
    clrOcc       = 1'b0;
    readPattern  = WORD_ZERO;
    lamInt       = 1'b0;
    lamNext      = 1'b0;
    setBit       = 1'b0;

    // Strobe edge at the selected polarity
    strobeActive        = strobe_input ^ cur.strobeCfg[STB_POL_BIT];
    strobeEvent         = strobeActive & ~cur.strobePrev;
    next_cur.strobePrev = strobeActive;
    next_cur.levelPrev  = levelIn;

    clrIn  = isCmd(cycleStrobe, func, subAddr, F_READ_CLR, A_DATA);
    clrOcc = isCmd(cycleStrobe, func, subAddr, F_READ_CLR, A_STROBE);

    // Channel data paths
    for (int i = 0; i < CHANNELS; i++) begin
      if (cfgIsIn[i]) begin
        if (cfgStrobed[i]) begin
          setBit = 1'b0;
        end else if (cfgNormal[i]) begin
          setBit = levelIn[i];
        end else begin
          setBit = levelIn[i] ^ cur.levelPrev[i];
        end
        if (cfgStrobed[i] && strobeEvent) begin
          next_cur.inLatch[i] = levelIn[i];
        end else begin
          next_cur.inLatch[i] = (cur.inLatch[i] & ~clrIn) | setBit;
        end
        if (!cfgStrobed[i] && cfgNormal[i]) begin
          readPattern[i] = cur.inLatch[i] | levelIn[i];
        end else begin
          readPattern[i] = cur.inLatch[i];
        end
        next_cur.driveVal[i] = 1'b0;
      end else begin
        next_cur.inLatch[i] = 1'b0;
        if (!cfgNormal[i]) begin
          next_cur.driveVal[i] = strobeActive & cur.outLatch[i];
        end else if (cfgStrobed[i]) begin
          if (strobeEvent) begin
            next_cur.driveVal[i] = cur.outLatch[i];
          end
        end else begin
          next_cur.driveVal[i] = cur.outLatch[i];
        end
        readPattern[i] = cur.driveVal[i];
      end
      next_cur.dirLed[i] = ~cfgIsIn[i];
    end

    // Strobe occurrence, set wins over clear
    next_cur.strobeCfg[STB_OCC_BIT] = (cur.strobeCfg[STB_OCC_BIT] & ~clrOcc) | strobeEvent;

    lamInt = (|(cur.lamMask & cur.inLatch)) |
             (cur.strobeCfg[STB_OCC_BIT] & cur.strobeCfg[STB_LAM_BIT]);

    // Dataway operation
    next_cur.respValid = cycleStrobe;
    next_cur.qResp     = 1'b0;
    if (cycleStrobe) begin
      next_cur.qResp = 1'b1;
      case (func)
        F_READ: begin
          case (subAddr)
            A_DATA: begin
              next_cur.readData = readPattern;
            end
            A_STROBE: begin
              next_cur.readData = {STB_PAD, cur.strobeCfg};
            end
            A_MASK: begin
              next_cur.readData = cur.lamMask;
            end
            default: begin
              next_cur.readData = WORD_ZERO;
              next_cur.qResp    = 1'b0;
            end
          endcase
        end
        F_READ_CFG: begin
          next_cur.readData = {12'h000, cfgAll[subAddr]};
        end
        F_READ_CLR: begin
          case (subAddr)
            A_DATA: begin
              next_cur.readData = readPattern;
            end
            A_STROBE: begin
              next_cur.readData = {STB_PAD, cur.strobeCfg};
            end
            default: begin
              next_cur.readData = WORD_ZERO;
              next_cur.qResp    = 1'b0;
            end
          endcase
        end
        F_WRITE: begin
          case (subAddr)
            A_DATA: begin
              next_cur.outLatch = writeData;
            end
            A_STROBE: begin
              next_cur.strobeCfg[STB_POL_BIT] = writeData[STB_POL_BIT];
              next_cur.strobeCfg[STB_LAM_BIT] = writeData[STB_LAM_BIT];
            end
            A_MASK: begin
              next_cur.lamMask = writeData;
            end
            default: begin
              next_cur.qResp = 1'b0;
            end
          endcase
        end
        F_WRITE_CFG: begin
          next_cur.qResp = 1'b1;
        end
        F_INIT: begin
          next_cur.qResp = (subAddr == A_DATA);
        end
        F_TEST_LAM: begin
          next_cur.qResp = cur.lamLine;
        end
        F_TEST_INT: begin
          next_cur.qResp = lamInt;
        end
        F_LAM_ON: begin
          next_cur.lamLineEn = 1'b1;
        end
        F_LAM_OFF: begin
          next_cur.lamLineEn = 1'b0;
        end
        default: begin
          next_cur.qResp = 1'b0;
        end
      endcase
    end

    // Reinitialise to power-up state
    if (initReq) begin
      next_cur.outLatch  = WORD_ZERO;
      next_cur.inLatch   = WORD_ZERO;
      next_cur.lamMask   = WORD_ZERO;
      next_cur.strobeCfg = STB_CFG_RESET;
      next_cur.lamLineEn = 1'b0;
      next_cur.driveVal  = WORD_ZERO;
      next_cur.dirLed    = WORD_ZERO;
    end

    // Pins follow drive value through channel polarity
    for (int i = 0; i < CHANNELS; i++) begin
      next_cur.pinOut[i] = cfgPol[i] ? next_cur.driveVal[i] : ~next_cur.driveVal[i];
    end

    // LAM from the state being entered
    lamNext = (|(next_cur.lamMask & next_cur.inLatch)) |
              (next_cur.strobeCfg[STB_OCC_BIT] & next_cur.strobeCfg[STB_LAM_BIT]);
    next_cur.lamLed  = lamNext & ~initReq;
    next_cur.lamLine = lamNext & next_cur.lamLineEn & ~initReq;
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cur.outLatch   <= WORD_ZERO;
      cur.inLatch    <= WORD_ZERO;
      cur.lamMask    <= WORD_ZERO;
      cur.strobeCfg  <= STB_CFG_RESET;
      cur.lamLineEn  <= 1'b0;
      cur.strobePrev <= 1'b0;
      cur.levelPrev  <= WORD_ZERO;
      cur.driveVal   <= WORD_ZERO;
      cur.pinOut     <= WORD_ZERO;
      cur.dirLed     <= WORD_ZERO;
      cur.readData   <= WORD_ZERO;
      cur.qResp      <= 1'b0;
      cur.respValid  <= 1'b0;
      cur.lamLine    <= 1'b0;
      cur.lamLed     <= 1'b0;
    end else begin
      cur <= next_cur;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign readData                    = cur.readData;
  assign qResp                       = cur.qResp;
  assign respValid                   = cur.respValid;
  assign lamLine                     = cur.lamLine;
  assign chanOut                     = cur.pinOut;
  assign chanOe                      = ~cfgIsIn;
  assign channel_direction_indicator = cur.dirLed;
  assign lamIndicator                = cur.lamLed;

endmodule

// ---- bench/pior_io_register_checker.sv ----
// Assertion checker on the ports of the I/O register
`timescale 1ns/1ps
module pior_io_register_checker (
  // Clock and reset
  input wire logic                          clk,
  input wire logic                          rst_b,
  // Dataway
  input wire logic                          cycleStrobe,
  input wire logic [pior_pkg::FUNC_W-1:0]   func,
  input wire logic [pior_pkg::ADDR_W-1:0]   subAddr,
  input wire logic                          datawayClear,
  input wire logic                          qResp,
  input wire logic                          respValid,
  input wire logic                          lamLine,
  // Pins and indicators
  input wire logic [pior_pkg::CHANNELS-1:0] chanOe,
  input wire logic [pior_pkg::CHANNELS-1:0] channel_direction_indicator,
  input wire logic                          lamIndicator
);
  import pior_pkg::*;
  logic       clrNow;
  logic       initNow;
  logic [1:0] clrHist;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // ---------------------------------------------------------------
  // Operations that may lawfully drop LAM
  // ---------------------------------------------------------------
  assign clrNow = datawayClear |
                  (cycleStrobe & (func inside {F_READ_CLR, F_INIT, F_WRITE, F_WRITE_CFG}));
  // Reinitialise forces the indicators dark at once
  assign initNow = datawayClear | (cycleStrobe && func == F_INIT && subAddr == A_DATA);
  always_ff @(posedge clk) begin
    if (!rst_b) clrHist <= 2'h3;
    else clrHist <= {clrHist[0], clrNow};
  end
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  sequence s_test_line;
    cycleStrobe && func == F_TEST_LAM;
  endsequence
  sequence s_test_int;
    cycleStrobe && func == F_TEST_INT;
  endsequence
  sequence s_lam_off;
    cycleStrobe && func == F_LAM_OFF;
  endsequence
  sequence s_init;
    cycleStrobe && func == F_INIT && subAddr == A_DATA;
  endsequence
  a_resp_follows_op: assert property (cycleStrobe |=> respValid)
    else $error("answer missing after operation");
  a_q_needs_valid: assert property (!respValid |-> !qResp)
    else $error("Q outside an answer");
  a_q_line_test: assert property (s_test_line |=> qResp == $past(lamLine))
    else $error("line test Q wrong");
  a_q_internal_test: assert property (s_test_int |=> qResp == $past(lamIndicator))
    else $error("internal test Q wrong");
  a_line_disable: assert property
    (s_lam_off ##1 !(cycleStrobe && func == F_LAM_ON) |=> !lamLine)
    else $error("LAM line still driven after disable");
  a_line_gated: assert property (lamLine |-> lamIndicator)
    else $error("LAM line without internal LAM");
  a_dir_indicator: assert property
    (!$past(initNow) |-> channel_direction_indicator == $past(chanOe))
    else $error("direction indicator does not follow direction");
  a_init_op: assert property
    (s_init |=> (qResp && chanOe == '0 && channel_direction_indicator == '0) ##1 !lamLine)
    else $error("initialise did not restore defaults");
  a_init_refused: assert property
    (cycleStrobe && func == F_INIT && subAddr != A_DATA |=> !qResp)
    else $error("initialise at wrong subaddress accepted");
  a_lam_holds: assert property ($fell(lamIndicator) |-> |clrHist)
    else $error("LAM dropped without clearing operation");
  a_reset_state: assert property
    ($rose(rst_b) |-> chanOe == '0 && channel_direction_indicator == '0 && !lamLine)
    else $error("state after reset wrong");
endmodule
bind pior_io_register pior_io_register_checker i_chk (
  .clk(clk), .rst_b(rst_b), .cycleStrobe(cycleStrobe), .func(func), .subAddr(subAddr),
  .datawayClear(datawayClear), .qResp(qResp), .respValid(respValid), .lamLine(lamLine),
  .chanOe(chanOe), .channel_direction_indicator(channel_direction_indicator),
  .lamIndicator(lamIndicator)
);

// ---- bench/pior_ctrl_model.sv ----
// Dataway controller model, one operation at a time
`timescale 1ns/1ps
module pior_ctrl_model (
  // Clock
  input  wire logic                        clk,
  // Command
  output logic                             cycleStrobe,
  output logic [pior_pkg::FUNC_W-1:0]      func,
  output logic [pior_pkg::ADDR_W-1:0]      subAddr,
  output logic [pior_pkg::DATA_W-1:0]      writeData,
  // Answer
  input  wire logic [pior_pkg::DATA_W-1:0] readData,
  input  wire logic                        qResp,
  input  wire logic                        respValid
);
  import pior_pkg::*;
  initial begin
    cycleStrobe = 1'b0;
    func = 5'h00;
    subAddr = 4'hF;
    writeData = 16'hA5A5;
  end
  // Idle address and data lines carry an inverted copy so nothing relies on stale values
  task automatic op(input logic [FUNC_W-1:0] f, input logic [ADDR_W-1:0] a,
                    input logic [DATA_W-1:0] w, output logic [DATA_W-1:0] rd,
                    output logic q, output logic ok);
    @(negedge clk);
    cycleStrobe = 1'b1;
    func = f;
    subAddr = a;
    writeData = w;
    @(negedge clk);
    ok = respValid;
    rd = readData;
    q = qResp;
    cycleStrobe = 1'b0;
    subAddr = ~a;
    writeData = ~w;
  endtask
endmodule

// ---- bench/pior_io_register_bench.sv ----
// Self-checking bench for the sixteen-channel I/O register
`timescale 1ns/1ps
module pior_io_register_bench;
  import pior_pkg::*;
  logic                clk, rst_b, datawayClear, strobe_input, q;
  logic                cycleStrobe, qResp, respValid, lamLine, lamIndicator;
  logic [FUNC_W-1:0]   func;
  logic [ADDR_W-1:0]   subAddr;
  logic [DATA_W-1:0]   writeData, readData, rd;
  logic [CHANNELS-1:0] chanIn, chanOut, chanOe, dirLed;
  int                  badCount, checkCount, cycles;
  pior_io_register i_pior_io_register (
    .clk(clk), .rst_b(rst_b), .cycleStrobe(cycleStrobe), .func(func), .subAddr(subAddr),
    .writeData(writeData), .datawayClear(datawayClear), .readData(readData), .qResp(qResp),
    .respValid(respValid), .lamLine(lamLine), .chanIn(chanIn), .chanOut(chanOut),
    .chanOe(chanOe), .strobe_input(strobe_input), .channel_direction_indicator(dirLed),
    .lamIndicator(lamIndicator));
  pior_ctrl_model i_pior_ctrl_model (
    .clk(clk), .cycleStrobe(cycleStrobe), .func(func), .subAddr(subAddr),
    .writeData(writeData), .readData(readData), .qResp(qResp), .respValid(respValid));
  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    checkCount++;
    if (seen !== exp) begin
      badCount++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic cmd(input logic [FUNC_W-1:0] f, input logic [ADDR_W-1:0] a,
                     input logic [DATA_W-1:0] w);
    logic ok;
    i_pior_ctrl_model.op(f, a, w, rd, q, ok);
    check({15'h0000, ok}, 16'h0001, "answer");
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic finishTest;
    $display("comparisons %0d mismatches %0d", checkCount, badCount);
    if (badCount == 0 && checkCount > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic testReset;
    for (int n = 0; n < 16; n++) begin
      cmd(F_READ_CFG, 4'(n), 16'h0000);
      check(rd & 16'h000F, 16'h0007, "channel config");
    end
    cmd(F_READ, A_STROBE, 16'h0000);
    check(rd & 16'h0007, 16'h0000, "strobe config");
    cmd(F_READ, A_MASK, 16'h0000);
    check(rd, 16'h0000, "mask");
    check({dirLed}, 16'h0000, "indicators");
    check({15'h0000, lamIndicator}, 16'h0000, "LAM indicator");
    $display("test reset done");
  endtask
  task automatic testOutput;
    cmd(F_WRITE_CFG, 4'h3, 16'h0006);
    cmd(F_READ_CFG, 4'h3, 16'h0000);
    check(rd & 16'h000F, 16'h0006, "config readback");
    cmd(F_WRITE, A_DATA, 16'h0008);
    cyc(2);
    check(chanOut & 16'h0008, 16'h0008, "output pin");
    check(chanOe & 16'h0008, 16'h0008, "output enable");
    check(dirLed & 16'h0008, 16'h0008, "indicator on");
    cmd(F_READ, A_DATA, 16'h0000);
    check(rd & 16'h0008, 16'h0008, "driven value read");
    cmd(F_WRITE_CFG, 4'h3, 16'h0004);
    cyc(2);
    check(chanOut & 16'h0008, 16'h0000, "negative pin");
    cmd(F_WRITE_CFG, 4'h3, 16'h0007);
    cyc(2);
    check(dirLed & 16'h0008, 16'h0000, "indicator off");
    $display("test output done");
  endtask
  task automatic testInput;
    chanIn[5] = 1'b1;
    cyc(2);
    chanIn[5] = 1'b0;
    cmd(F_READ_CLR, A_DATA, 16'h0000);
    check(rd & 16'h0020, 16'h0020, "captured input");
    cmd(F_READ, A_DATA, 16'h0000);
    check(rd & 16'h0020, 16'h0000, "cleared input");
    cmd(F_WRITE_CFG, 4'h6, 16'h0003);
    chanIn[6] = 1'b1;
    cyc(1);
    chanIn[6] = 1'b0;
    cmd(F_READ_CLR, A_DATA, 16'h0000);
    check(rd & 16'h0040, 16'h0040, "glitch seen");
    cmd(F_READ, A_DATA, 16'h0000);
    check(rd & 16'h0040, 16'h0000, "glitch cleared");
    $display("test input done");
  endtask
  task automatic testMaskLam;
    cmd(F_WRITE, A_MASK, 16'h0020);
    cmd(F_TEST_INT, A_DATA, 16'h0000);
    check({15'h0000, q}, 16'h0000, "no LAM yet");
    chanIn[5] = 1'b1;
    cyc(2);
    chanIn[5] = 1'b0;
    cyc(2);
    cmd(F_TEST_INT, A_DATA, 16'h0000);
    check({15'h0000, q}, 16'h0001, "internal LAM");
    check({15'h0000, lamIndicator}, 16'h0001, "LAM indicator on");
    cmd(F_TEST_LAM, A_DATA, 16'h0000);
    check({15'h0000, q}, 16'h0000, "line disabled");
    cmd(F_LAM_ON, A_DATA, 16'h0000);
    cyc(2);
    check({15'h0000, lamLine}, 16'h0001, "line enabled");
    cmd(F_TEST_LAM, A_DATA, 16'h0000);
    check({15'h0000, q}, 16'h0001, "line test");
    cmd(F_LAM_OFF, A_DATA, 16'h0000);
    cyc(2);
    check({15'h0000, lamLine}, 16'h0000, "line off");
    cmd(F_READ, A_DATA, 16'h0000);
    cmd(F_TEST_INT, A_DATA, 16'h0000);
    check({15'h0000, q}, 16'h0001, "LAM kept");
    cmd(F_READ_CLR, A_DATA, 16'h0000);
    cyc(2);
    cmd(F_TEST_INT, A_DATA, 16'h0000);
    check({15'h0000, q}, 16'h0000, "LAM cleared");
    check({15'h0000, lamIndicator}, 16'h0000, "LAM indicator off");
    $display("test mask done");
  endtask
  task automatic testStrobe;
    cmd(F_WRITE_CFG, 4'h7, 16'h000F);
    cmd(F_WRITE_CFG, 4'h8, 16'h000E);
    cmd(F_WRITE, A_STROBE, 16'h0002);
    cmd(F_WRITE, A_DATA, 16'h0100);
    chanIn[7] = 1'b1;
    cyc(1);
    strobe_input = 1'b1;
    cyc(3);
    strobe_input = 1'b0;
    chanIn[7] = 1'b0;
    cyc(2);
    check(chanOut & 16'h0100, 16'h0100, "strobed output");
    cmd(F_READ, A_DATA, 16'h0000);
    check(rd & 16'h0080, 16'h0080, "strobed input");
    cmd(F_READ, A_STROBE, 16'h0000);
    check(rd & 16'h0007, 16'h0006, "strobe seen");
    cmd(F_TEST_INT, A_DATA, 16'h0000);
    check({15'h0000, q}, 16'h0001, "strobe LAM");
    cmd(F_READ_CLR, A_STROBE, 16'h0000);
    check(rd & 16'h0007, 16'h0006, "read and clear");
    cmd(F_READ, A_STROBE, 16'h0000);
    check(rd & 16'h0007, 16'h0002, "bit two cleared");
    cmd(F_TEST_INT, A_DATA, 16'h0000);
    check({15'h0000, q}, 16'h0000, "strobe LAM gone");
    cmd(F_WRITE, A_STROBE, 16'h0000);
    strobe_input = 1'b1;
    cyc(2);
    cmd(F_READ_CLR, A_STROBE, 16'h0000);
    cmd(F_WRITE, A_STROBE, 16'h0001);
    cmd(F_READ, A_STROBE, 16'h0000);
    check(rd & 16'h0007, 16'h0001, "negative polarity");
    strobe_input = 1'b0;
    cyc(2);
    cmd(F_READ, A_STROBE, 16'h0000);
    check(rd & 16'h0007, 16'h0005, "falling strobe");
    cmd(F_TEST_INT, A_DATA, 16'h0000);
    check({15'h0000, q}, 16'h0000, "no strobe LAM");
    $display("test strobe done");
  endtask
  task automatic testInit;
    cmd(F_INIT, A_STROBE, 16'h0000);
    check({15'h0000, q}, 16'h0000, "refused init");
    cmd(F_INIT, A_DATA, 16'h0000);
    check({15'h0000, q}, 16'h0001, "init");
    cmd(F_READ_CFG, 4'h8, 16'h0000);
    check(rd & 16'h000F, 16'h0007, "config after init");
    cmd(F_WRITE, A_MASK, 16'h00FF);
    datawayClear = 1'b1;
    cyc(1);
    datawayClear = 1'b0;
    cmd(F_READ, A_MASK, 16'h0000);
    check(rd, 16'h0000, "mask after clear");
    $display("test init done");
  endtask
  // ---------------------------------------------------------------
  // Clock, timeout and main sequence
  // ---------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      badCount++;
      finishTest;
    end
  end
  initial begin
    rst_b = 1'b0;
    datawayClear = 1'b0;
    strobe_input = 1'b0;
    chanIn = 16'h0000;
    cyc(2);
    rst_b = 1'b1;
    testReset;
    testOutput;
    testInput;
    testMaskLam;
    testStrobe;
    testInit;
    finishTest;
  end
endmodule
